// [rtl/boot_size_map.sv]
`timescale 1ns/10ps
module boot_size_map
  import flash_prog_pkg::*;
(
  // Boot size setting
  input  wire logic [1:0]  boot_size_select_in,
  // Section limits
  output logic      [14:0] boot_start_out,
  output logic      [14:0] app_end_out
);

  always_comb begin
    unique case (boot_size_select_in)
      2'h3: begin // [R3]
        boot_start_out = BOOT_START_512;
        app_end_out    = APP_END_512;
      end
      2'h2: begin // [R4]
        boot_start_out = BOOT_START_1K;
        app_end_out    = APP_END_1K;
      end
      2'h1: begin // [R5]
        boot_start_out = BOOT_START_2K;
        app_end_out    = APP_END_2K;
      end
      2'h0: begin // [R6]
        boot_start_out = BOOT_START_4K;
        app_end_out    = APP_END_4K;
      end
    endcase
  end

endmodule

// [rtl/flash_prog_pkg.sv]
package flash_prog_pkg;

  // ----------------------------------------------------------------
  // Flash geometry
  // ----------------------------------------------------------------
  localparam int          COUNTER_TOP_BIT           = 14;
  localparam int          PAGE_WORD_TOP_BIT         = 6;
  localparam int          POINTER_COUNTER_TOP_BIT   = 15;
  localparam int          POINTER_PAGE_WORD_TOP_BIT = 7;
  localparam logic [14:0] HALT_REGION_START         = 15'h7000;

  // ----------------------------------------------------------------
  // Boot section starts and application ends
  // ----------------------------------------------------------------
  localparam logic [14:0] BOOT_START_512  = 15'h7E00;
  localparam logic [14:0] BOOT_START_1K   = 15'h7C00;
  localparam logic [14:0] BOOT_START_2K   = 15'h7800;
  localparam logic [14:0] BOOT_START_4K   = 15'h7000;
  localparam logic [14:0] APP_END_512     = 15'h7DFF;
  localparam logic [14:0] APP_END_1K      = 15'h7BFF;
  localparam logic [14:0] APP_END_2K      = 15'h77FF;
  localparam logic [14:0] APP_END_4K      = 15'h6FFF;

  // ----------------------------------------------------------------
  // Register map and control fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PTR  = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_EXEC = 8'h0C;
  localparam logic [7:0] ADDR_MAP  = 8'h10;
  localparam int         EN_BIT    = 0;
  localparam int         ERASE_BIT = 1;
  localparam int         WRITE_BIT = 2;
  localparam int         LOCK_BIT  = 3;
  localparam int         REEN_BIT  = 4;
  localparam int         BUSY_BIT  = 6;
  localparam logic [4:0] CMD_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_WINDOW  = 3'h4;
  localparam int         PROG_MIN_US = 3700;
  localparam int         PROG_MAX_US = 4500;
  localparam int         RC_FREQ_KHZ = 1000;
  localparam int         PROG_TICKS  =
    ((PROG_MIN_US + PROG_MAX_US) / 2) * RC_FREQ_KHZ / 1000;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PROG} prog_state_t;

  function automatic logic in_halting(input logic [14:0] addr);
    in_halting = (addr >= HALT_REGION_START);
  endfunction

endpackage

// [rtl/flash_self_prog.sv]
`timescale 1ns/10ps
// Summary of operation
// (R1) Erase and write durations are counted on RC oscillator edges.
// (R2) Erase, page write and lock write last between 3.7 and 4.5 ms.
// (R3) Setting 11: boot 0x7E00-0x7FFF, application ends 0x7DFF.
// (R4) Setting 10: boot from 0x7C00, application ends 0x7BFF.
// (R5) Setting 01: boot from 0x7800, application ends 0x77FF.
// (R6) Setting 00: boot from 0x7000, application ends 0x6FFF.
// (R7) Words 0x0000-0x6FFF form the concurrent-read region, 224 pages.
// (R8) Words 0x7000-0x7FFF halt the CPU while programmed, 32 pages.
// (R9) Program counter is 15 word-address bits.
// (R10) Pages hold 128 words; low seven bits pick the word.
// (R11) Erase and write take the page from pointer bits 15 to 8.
// (R12) Pointer bits 7 to 1 pick the buffer word; zero for page write.
// (R13) Pointer bit 0 is load byte select, ignored by store commands.
// (R14) During erase or write only the halting region may be read.
// (R15) Software polls the enable bit low before a new command.
// (R16) Control writes wait for EEPROM writes to finish.
// (R17) After programming, re-enable clears busy before region reads.
// (R18) Enable alone stores the data word at the pointer's buffer word.
// (R19) Software masks or relocates interrupts during programming.
// (R20) Command acts only if executed within four cycles, else clears.
// (R21) Busy stays set until software writes the re-enable command.
// (R22) Enable bit stays set through the operation, clears at the end.
// (R23) Execute requests during an operation are ignored.
module flash_self_prog
  import flash_prog_pkg::*;
#(
  parameter int PROG_TICKS_P = PROG_TICKS
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Device inputs
  input  wire logic        rc_osc_in,
  input  wire logic [1:0]  boot_size_select_in,
  input  wire logic        eeprom_write_active_in,
  input  wire logic [14:0] fetch_addr_in,
  // Flash array commands
  output logic             buf_wr_out,
  output logic      [6:0]  word_select_out,
  output logic      [15:0] buf_data_out,
  output logic             page_erase_out,
  output logic             page_write_out,
  output logic             lock_write_out,
  output logic      [7:0]  page_select_out,
  output logic      [7:0]  lock_data_out,
  output logic             read_byte_sel_out,
  // Status to the core
  output logic             cpu_halt_out,
  output logic             fetch_ok_out,
  output logic      [14:0] boot_start_out,
  output logic      [14:0] app_end_out
);

  prog_state_t state_q;
  logic [4:0]  cmd_q;
  logic [2:0]  window_q;
  logic        busy_q;
  logic [15:0] ptr_q;
  logic [15:0] data_q;
  logic        strap_done_q;
  logic [14:0] map_start;
  logic [14:0] map_end;
  logic        timer_done;
  logic        timer_start_q;
  logic        wr_hit;
  logic        ctrl_wr;
  logic        exec_hit;
  logic        exec_fill;
  logic        exec_reen;
  logic        exec_long;
  logic [14:0] target_pc;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = (addr == ADDR_CTRL) || (addr == ADDR_PTR) ||
                 (addr == ADDR_DATA) || (addr == ADDR_EXEC) ||
                 (addr == ADDR_MAP);
  endfunction

  assign wr_hit    = psel & penable & pready & pwrite & ~pslverr;
  assign ctrl_wr   = wr_hit & (paddr == ADDR_CTRL);
  assign exec_hit  = wr_hit & (paddr == ADDR_EXEC);
  assign exec_long = cmd_q[ERASE_BIT] | cmd_q[WRITE_BIT] | cmd_q[LOCK_BIT];
  assign exec_reen = ~exec_long & cmd_q[REEN_BIT];
  assign exec_fill = ~exec_long & ~cmd_q[REEN_BIT];
  // Page from pointer bits 15..8, i.e. PC bits 14..7
  assign target_pc = {ptr_q[POINTER_COUNTER_TOP_BIT:
                            POINTER_PAGE_WORD_TOP_BIT + 1],
                      7'h00}; // [R9] [R10] [R11]

  // ----------------------------------------------------------------
  // APB slave, one wait-free access phase
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~reg_mapped(paddr);
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ADDR_CTRL: prdata <= {25'h0, busy_q, 1'b0, cmd_q};
          ADDR_PTR:  prdata <= {16'h0000, ptr_q};
          ADDR_DATA: prdata <= {16'h0000, data_q};
          ADDR_MAP:  prdata <= {1'b0, map_end, 1'b0, map_start};
          default:   prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_q  <= 16'h0000;
      data_q <= 16'h0000;
    end else if (wr_hit && paddr == ADDR_PTR) begin
      ptr_q <= pwdata[15:0];
    end else if (wr_hit && paddr == ADDR_DATA) begin
      data_q <= pwdata[15:0]; // [R18]
    end
  end

  // ----------------------------------------------------------------
  // Boot size strap and section map
  // ----------------------------------------------------------------
  boot_size_map u_map (
    .boot_size_select_in (boot_size_select_in),
    .boot_start_out      (map_start),
    .app_end_out         (map_end)
  );

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_done_q   <= 1'b0;
      boot_start_out <= BOOT_START_4K;
      app_end_out    <= APP_END_4K;
    end else if (!strap_done_q) begin
      strap_done_q   <= 1'b1;
      boot_start_out <= map_start; // [R3] [R4] [R5] [R6]
      app_end_out    <= map_end;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  rc_prog_timer #(
    .PROG_TICKS_P (PROG_TICKS_P)
  ) u_timer (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .rc_osc_in  (rc_osc_in),
    .start_in   (timer_start_q),
    .done_out   (timer_done)
  );

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q       <= ST_IDLE;
      cmd_q         <= CMD_RESET;
      window_q      <= 3'h0;
      timer_start_q <= 1'b0;
    end else begin
      timer_start_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          // EEPROM write in flight blocks the control write
          if (ctrl_wr && pwdata[EN_BIT] &&
              !eeprom_write_active_in) begin // [R16]
            state_q  <= ST_ARMED;
            cmd_q    <= pwdata[4:0];
            window_q <= CMD_WINDOW;
          end
        end
        ST_ARMED: begin
          if (exec_hit && exec_long) begin
            state_q       <= ST_PROG; // [R22]
            timer_start_q <= 1'b1;
          end else if (exec_hit) begin
            state_q <= ST_IDLE;
            cmd_q   <= CMD_RESET;
          end else if (window_q == 3'h1) begin
            state_q <= ST_IDLE; // [R20]
            cmd_q   <= CMD_RESET;
          end else begin
            window_q <= window_q - 3'h1;
          end
        end
        ST_PROG: begin
          // New execute requests fall through unheeded
          if (timer_done) begin // [R23]
            state_q <= ST_IDLE; // [R22]
            cmd_q   <= CMD_RESET;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flash array strobes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      buf_wr_out      <= 1'b0;
      word_select_out <= 7'h00;
      buf_data_out    <= 16'h0000;
      page_erase_out  <= 1'b0;
      page_write_out  <= 1'b0;
      lock_write_out  <= 1'b0;
      page_select_out <= 8'h00;
      lock_data_out   <= 8'h00;
    end else begin
      buf_wr_out     <= 1'b0;
      page_erase_out <= 1'b0;
      page_write_out <= 1'b0;
      lock_write_out <= 1'b0;
      if (state_q == ST_ARMED && exec_hit) begin
        // Pointer bit 0 is not used by store commands
        if (exec_fill) begin // [R13]
          buf_wr_out      <= 1'b1; // [R18]
          word_select_out <= ptr_q[POINTER_PAGE_WORD_TOP_BIT:1]; // [R12]
          buf_data_out    <= data_q;
        end
        page_erase_out  <= cmd_q[ERASE_BIT];
        page_write_out  <= ~cmd_q[ERASE_BIT] & cmd_q[WRITE_BIT];
        lock_write_out  <= ~cmd_q[ERASE_BIT] & ~cmd_q[WRITE_BIT] &
                           cmd_q[LOCK_BIT];
        page_select_out <= ptr_q[15:8]; // [R11]
        lock_data_out   <= data_q[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      read_byte_sel_out <= 1'b0;
    end else begin
      read_byte_sel_out <= ptr_q[0]; // [R13]
    end
  end

  // ----------------------------------------------------------------
  // Region blocking and CPU halt
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_q <= 1'b0;
    end else if (state_q == ST_ARMED && exec_hit &&
                 (cmd_q[ERASE_BIT] || cmd_q[WRITE_BIT])) begin
      busy_q <= 1'b1; // [R14]
    end else if (state_q == ST_ARMED && exec_hit && exec_reen &&
                 state_q != ST_PROG) begin
      busy_q <= 1'b0; // [R17] [R21]
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cpu_halt_out <= 1'b0;
    end else if (state_q == ST_ARMED && exec_hit &&
                 (cmd_q[ERASE_BIT] || cmd_q[WRITE_BIT])) begin
      cpu_halt_out <= in_halting(target_pc); // [R7] [R8]
    end else if (timer_done) begin
      cpu_halt_out <= 1'b0; // [R8]
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fetch_ok_out <= 1'b1;
    end else begin
      fetch_ok_out <= in_halting(fetch_addr_in) | ~busy_q; // [R14] [R17]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence arm_seq;
    $rose(state_q == ST_ARMED);
  endsequence

  sequence no_exec_seq;
    (!exec_hit)[*4];
  endsequence

  window_expiry_a: assert property ( // [R20]
    arm_seq ##0 no_exec_seq |=> state_q == ST_IDLE && cmd_q == CMD_RESET)
    else $error("command survived its four-cycle window");

  busy_hold_a: assert property ( // [R21]
    busy_q && !(state_q == ST_ARMED && exec_hit && exec_reen) |=> busy_q)
    else $error("busy flag dropped without re-enable");

  enable_hold_a: assert property ( // [R22]
    state_q == ST_PROG && !timer_done |=> cmd_q[EN_BIT])
    else $error("enable bit cleared during programming");

  prog_ignore_a: assert property ( // [R23]
    state_q == ST_PROG && exec_hit |=>
      !buf_wr_out && !page_erase_out && !page_write_out)
    else $error("execute accepted while programming");

  fetch_block_a: assert property ( // [R14]
    busy_q && !in_halting(fetch_addr_in) |=> !fetch_ok_out)
    else $error("concurrent region readable while busy");

  fill_word_a: assert property ( // [R18]
    state_q == ST_ARMED && exec_hit && exec_fill |=>
      buf_wr_out && word_select_out == $past(ptr_q[7:1]) &&
      buf_data_out == $past(data_q) && state_q == ST_IDLE)
    else $error("buffer fill went to wrong word");

  halt_region_a: assert property ( // [R8]
    state_q == ST_ARMED && exec_hit &&
    (cmd_q[ERASE_BIT] || cmd_q[WRITE_BIT]) &&
    ptr_q[15:13] == 3'h7 |=> cpu_halt_out ##0 busy_q)
    else $error("halting-region erase did not halt CPU");

  eeprom_block_a: assert property ( // [R16]
    state_q == ST_IDLE && ctrl_wr && eeprom_write_active_in
      |=> state_q == ST_IDLE)
    else $error("control write taken during EEPROM write");

  map_split_a: assert property ( // [R3]
    strap_done_q |-> app_end_out == boot_start_out - 15'h0001)
    else $error("application end does not abut boot start");

endmodule

// [rtl/rc_prog_timer.sv]
`timescale 1ns/10ps
module rc_prog_timer
  import flash_prog_pkg::*;
#(
  parameter int PROG_TICKS_P = PROG_TICKS
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // RC oscillator and control
  input  wire logic rc_osc_in,
  input  wire logic start_in,
  output logic      done_out
);

  logic [2:0]  sync_q;
  logic        level_q;
  logic        tick;
  logic [15:0] ticks_q;
  logic        run_q;

  // RC edge seen once second and third stages agree
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_q  <= 3'h0;
      level_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], rc_osc_in};
      if (sync_q[1] == sync_q[2]) begin
        level_q <= sync_q[2];
      end
    end
  end

  assign tick = sync_q[1] & sync_q[2] & ~level_q;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_q    <= 1'b0;
      ticks_q  <= 16'h0000;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        run_q   <= 1'b1;
        ticks_q <= 16'h0000;
      end else if (run_q && tick) begin // [R1]
        if (ticks_q == 16'(PROG_TICKS_P - 1)) begin // [R2]
          run_q    <= 1'b0;
          done_out <= 1'b1;
        end else begin
          ticks_q <= ticks_q + 16'h0001;
        end
      end
    end
  end

  prog_duration_a: assert property ( // [R2]
    @(posedge sys_clk_in) disable iff (rst_in)
    done_out |-> $past(ticks_q) == 16'(PROG_TICKS_P - 1) && $past(tick))
    else $error("programming ended before its tick count");

endmodule

// [verif/core_model.sv]
`timescale 1ns/10ps
module core_model
  import flash_prog_pkg::*;
(
  // Clock
  input  wire logic        sys_clk_in,
  // APB master
  output logic      [7:0]  paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Status
  input  wire logic        eeprom_write_active_in,
  output logic             hung_out
);
  initial begin
    paddr = 8'hFF;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'hFFFFFFFF;
    hung_out = 1'b0;
  end

  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n;
    @(posedge sys_clk_in);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) hung_out <= 1'b1;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  task automatic wait_idle();
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    do begin
      xfer(ADDR_CTRL, 1'b0, 32'h0, r, e);
      n++;
    end while (r[EN_BIT] !== 1'b0 && n < 400);
    if (r[EN_BIT] !== 1'b0) hung_out <= 1'b1;
  endtask

  // Store-program sequence; pointer bit 0 kept clear by callers
  // Model takes no interrupts, so no vector fetch hits a blocked region
  task automatic spm(input logic [4:0] c, input logic [15:0] z,
                     input logic [15:0] d);
    logic [31:0] r;
    logic        e;
    int          n;
    wait_idle();
    xfer(ADDR_PTR, 1'b1, {16'h0, z}, r, e);
    xfer(ADDR_DATA, 1'b1, {16'h0, d}, r, e);
    n = 0;
    while (eeprom_write_active_in !== 1'b0 && n < 100) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (eeprom_write_active_in !== 1'b0) hung_out <= 1'b1;
    xfer(ADDR_CTRL, 1'b1, {27'h0, c}, r, e);
    xfer(ADDR_EXEC, 1'b1, 32'h0, r, e);
  endtask
endmodule

// [verif/tb_boot_flash_self_program_map.sv]
`timescale 1ns/10ps
module tb_boot_flash_self_program_map
  import flash_prog_pkg::*;
;
  localparam int      TICKS  = 5;
  localparam realtime RC_PER = 1003.0;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        sys_clk_in, rst_in, psel, penable, pwrite, pready;
  logic        pslverr, rc_osc, ee_act, buf_wr, pg_erase, pg_write;
  logic        lk_write, byte_sel, halt, fetch_ok, hung;
  logic [1:0]  boot_sel;
  logic [6:0]  word_sel, cap_word;
  logic [7:0]  paddr, page_sel, lk_data, cap_page, cap_lock;
  logic [14:0] fetch_addr, boot_start, app_end;
  logic [15:0] buf_data, cap_data;
  logic [31:0] prdata, pwdata;
  int          errors, checks_done, n_fill, n_erase, n_write, n_lock;
  realtime     t_start;

  always #10 sys_clk_in = ~sys_clk_in;
  always #(RC_PER / 2) rc_osc = ~rc_osc;

  flash_self_prog #(.PROG_TICKS_P(TICKS)) i_dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_osc_in(rc_osc), .boot_size_select_in(boot_sel),
    .eeprom_write_active_in(ee_act), .fetch_addr_in(fetch_addr),
    .buf_wr_out(buf_wr), .word_select_out(word_sel),
    .buf_data_out(buf_data), .page_erase_out(pg_erase),
    .page_write_out(pg_write), .lock_write_out(lk_write),
    .page_select_out(page_sel), .lock_data_out(lk_data),
    .read_byte_sel_out(byte_sel), .cpu_halt_out(halt),
    .fetch_ok_out(fetch_ok), .boot_start_out(boot_start),
    .app_end_out(app_end));

  core_model i_core (
    .sys_clk_in(sys_clk_in), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eeprom_write_active_in(ee_act), .hung_out(hung));

  // ----------------------------------------------------------------
  // Pulse capture
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (buf_wr === 1'b1) begin
      n_fill++;
      cap_word = word_sel;
      cap_data = buf_data;
    end
    if (pg_erase === 1'b1 || pg_write === 1'b1) begin
      n_erase += (pg_erase === 1'b1);
      n_write += (pg_write === 1'b1);
      cap_page = page_sel;
      t_start = $realtime;
    end
    if (lk_write === 1'b1) begin
      n_lock++;
      cap_lock = lk_data;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    i_core.xfer(a, 1'b1, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    i_core.xfer(a, 1'b0, 32'h0, r, e);
  endtask

  task automatic fetch(input logic [14:0] a, input logic exp);
    fetch_addr <= a;
    repeat (2) @(posedge sys_clk_in);
    chk("fetch_ok", {31'h0, exp}, {31'h0, fetch_ok});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_map();
    logic [31:0] r;
    logic [15:0] bs;
    for (int s = 0; s < 4; s++) begin
      rst_in <= 1'b1;
      boot_sel <= s[1:0];
      repeat (2) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      bs = 16'h8000 - (16'h0200 << (3 - s));
      chk("boot_start", {17'h0, bs[14:0]}, {17'h0, boot_start});
      chk("app_end", {17'h0, bs[14:0] - 15'h1}, {17'h0, app_end});
      rd(ADDR_MAP, r);
      chk("map", {1'b0, bs[14:0] - 15'h1, 1'b0, bs[14:0]}, r);
    end
    $display("test map done");
  endtask

  task automatic t_fill();
    i_core.spm(5'h01, 16'h002A, 16'hBEEF);
    repeat (2) @(posedge sys_clk_in);
    chk("fills", 32'h1, n_fill);
    chk("word_sel", 32'h15, {25'h0, cap_word});
    chk("buf_data", 32'hBEEF, {16'h0, cap_data});
    wr(ADDR_PTR, 32'h0001);
    repeat (2) @(posedge sys_clk_in);
    chk("byte_sel", 32'h1, {31'h0, byte_sel});
    $display("test fill done");
  endtask

  task automatic t_erase();
    logic [31:0] r;
    realtime     dt;
    i_core.spm(5'h03, 16'h0100, 16'h0000);
    rd(ADDR_CTRL, r);
    chk("ctrl_run", 32'h41, r & 32'h41);
    chk("erases", 32'h1, n_erase);
    chk("page_sel", 32'h01, {24'h0, cap_page});
    chk("halt", 32'h0, {31'h0, halt});
    fetch(15'h0000, 1'b0);
    fetch(15'h7000, 1'b1);
    i_core.wait_idle();
    dt = $realtime - t_start;
    chk("prog_time", 32'h1, (dt >= (TICKS - 1) * RC_PER &&
        dt <= (TICKS + 1) * RC_PER + 200.0));
    rd(ADDR_CTRL, r);
    chk("ctrl_done", 32'h40, r & 32'h41);
    i_core.spm(5'h11, 16'h0000, 16'h0000);
    rd(ADDR_CTRL, r);
    chk("ctrl_reen", 32'h0, r);
    fetch(15'h0000, 1'b1);
    $display("test erase done");
  endtask

  task automatic t_write();
    i_core.spm(5'h05, 16'hE000, 16'h0000);
    repeat (2) @(posedge sys_clk_in);
    chk("halt", 32'h1, {31'h0, halt});
    chk("page_sel", 32'hE0, {24'h0, cap_page});
    wr(ADDR_EXEC, 32'h0);
    i_core.wait_idle();
    chk("writes", 32'h1, n_write);
    chk("halt_end", 32'h0, {31'h0, halt});
    i_core.spm(5'h11, 16'h0000, 16'h0000);
    $display("test write done");
  endtask

  task automatic t_refuse();
    logic [31:0] r;
    logic        e;
    i_core.spm(5'h09, 16'h0000, 16'h00C3);
    repeat (2) @(posedge sys_clk_in);
    chk("lock_data", 32'hC3, {24'h0, cap_lock});
    chk("locks", 32'h1, n_lock);
    i_core.wait_idle();
    wr(ADDR_CTRL, 32'h03);
    repeat (6) @(posedge sys_clk_in);
    wr(ADDR_EXEC, 32'h0);
    rd(ADDR_CTRL, r);
    chk("ctrl_expired", 32'h0, r);
    ee_act <= 1'b1;
    wr(ADDR_CTRL, 32'h03);
    rd(ADDR_CTRL, r);
    chk("ctrl_ee", 32'h0, r);
    ee_act <= 1'b0;
    chk("erases", 32'h1, n_erase);
    i_core.xfer(8'h20, 1'b0, 32'h0, r, e);
    chk("slverr", 32'h1, {31'h0, e});
    $display("test refuse done");
  endtask

  initial begin
    sys_clk_in = 1'b0;
    rst_in = 1'b1;
    rc_osc = 1'b0;
    ee_act = 1'b0;
    boot_sel = 2'h3;
    fetch_addr = 15'h0000;
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_map();
    t_fill();
    t_erase();
    t_write();
    t_refuse();
    close_out();
  end

  always @(posedge hung) begin
    errors++;
    close_out();
  end

  initial begin
    repeat (100000) @(posedge sys_clk_in);
    errors++;
    close_out();
  end
endmodule
